// ===== hdl/sgc_pkg.sv
// Behaviour
// (RQ1) Writing one to ROM reload bit starts a fresh ROM configuration load; bit self-clears.
// (RQ2) Software polls init-complete status flag rather than waiting a fixed delay.
// (RQ3) Full soft reset resets all logic including registers; bit self-clears, zero is normal.
// (RQ4) Logic soft reset resets logic but keeps configuration registers; bit self-clears.
// (RQ5) Software should prefer logic soft reset to keep its programmed configuration.
// (RQ6) Local I2C controller runs only while its enable bit is one; resets to zero.
// (RQ7) Policy bit zero: transmitter high impedance when no assigned port has lock.
// (RQ8) Policy bit one: transmitter follows per-port control; LP-11 when no lock and idle choice one.
// (RQ9) Idle choice one and output enable zero force transmitter to high impedance.
// (RQ10) No lock and idle choice zero hold transmitter outputs in HS-0.
// (RQ11) Receiver parity checking active only while its enable bit is one; resets to one.
// (RQ12) Override one reports reference clock present; zero passes detect circuit result.
// (RQ13) Read-only ident register: revision upper nibble, mask_rev_field lower nibble; writes ignored.
// (RQ14) Reserved bits in reset and configuration registers read zero, ignore writes.
// (RQ15) Init-complete flag, status bit 6, set once power-up or ROM load finishes.
// (RQ16) Reset and reload request bits read one while pending, zero once done.
package sgc_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // Register offsets
  localparam logic [7:0] SOFT_RESET_CONTROL_OFS = 8'h01;
  localparam logic [7:0] GENERAL_CONFIGURATION_OFS = 8'h02;
  localparam logic [7:0] SILICON_REVISION_IDENT_OFS = 8'h03;
  localparam logic [7:0] DEVICE_STATUS_REG_OFS = 8'h04;

  // Soft reset control fields
  localparam int unsigned RST_LOGIC_BIT = 0;
  localparam int unsigned RST_FULL_BIT = 1;
  localparam int unsigned RST_RELOAD_BIT = 2;

  // General configuration fields
  localparam int unsigned CFG_REFCLK_OVR_BIT = 0;
  localparam int unsigned CFG_PARITY_EN_BIT = 1;
  localparam int unsigned CFG_IDLE_CHOICE_BIT = 2;
  localparam int unsigned CFG_OUT_ENABLE_BIT = 3;
  localparam int unsigned CFG_NOLOCK_POLICY_BIT = 4;
  localparam int unsigned CFG_I2C_CTRL_EN_BIT = 5;
  localparam logic [7:0] CFG_WRITE_MASK = 8'h3F;
  localparam logic [7:0] CFG_RESET = 8'h1E;

  // Device status fields
  localparam int unsigned STS_INIT_DONE_BIT = 6;
  localparam int unsigned STS_REFCLK_BIT = 4;

  // Ident fields; values arbitrary
  localparam logic [3:0] SILICON_REV_DEFAULT = 4'hA;
  localparam logic [3:0] MASK_REV_DEFAULT = 4'h3;

  // Logic reset pulse length in cycles, less one
  localparam logic [3:0] LOGIC_RST_CYCLES = 4'h4;

  // Transmitter output state
  typedef enum logic [3:0] {
    SGC_TX_NORMAL = 4'h1,
    SGC_TX_HIZ = 4'h2,
    SGC_TX_LP11 = 4'h4,
    SGC_TX_HS0 = 4'h8
  } sgc_tx_state_t;

  // ROM loader states
  typedef enum logic [2:0] {
    SGC_LD_IDLE = 3'h1,
    SGC_LD_RUN = 3'h2,
    SGC_LD_DONE = 3'h4
  } sgc_ld_state_t;

  // Register bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } sgc_bus_req_t;

  // Block controls toward the rest of the device
  typedef struct packed {
    logic i2c_ctrl_en;
    logic parity_check_en;
    logic refclk_present;
    sgc_tx_state_t tx_state;
    logic logic_reset;
  } sgc_ctrl_t;

endpackage : sgc_pkg

// ===== hdl/sgc_rom.sv
`timescale 1ns/1ps
// Configuration ROM; read data registered
module sgc_rom #(
  parameter int unsigned DEPTH = 8,
  parameter int unsigned AW = 3
) (
  // Clock
  input wire logic clk_i,
  // Read port
  input wire logic [AW-1:0] addr_i,
  output logic [7:0] data_o
);

  logic [7:0] data_q;

  function automatic logic [7:0] rom_word(input logic [AW-1:0] a);
    // Last word carries the default configuration image
    if (a == AW'(DEPTH - 1)) begin
      return sgc_pkg::CFG_RESET;
    end
    return 8'h00;
  endfunction : rom_word

  always_ff @(posedge clk_i) begin
    data_q <= rom_word(addr_i);
  end

  assign data_o = data_q;

endmodule : sgc_rom

// ===== hdl/sgc_top.sv
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
module sgc_top #(
  parameter int unsigned ROM_DEPTH = 8,
  parameter int unsigned ROM_AW = 3
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Status inputs from pins
  input wire logic any_rx_lock_i,
  input wire logic refclk_detect_i,
  // Controls
  output logic i2c_ctrl_en_o,
  output logic parity_check_en_o,
  output logic refclk_present_o,
  output sgc_pkg::sgc_tx_state_t tx_state_o,
  output logic logic_reset_o,
  output logic init_done_o
);

  typedef struct packed {
    logic [1:0] lock_sync;
    logic [1:0] refclk_sync;
    logic [7:0] cfg;
    logic reload_pend;
    logic full_pend;
    logic logic_pend;
    logic [3:0] logic_cnt;
    sgc_pkg::sgc_ld_state_t ld_state;
    logic [ROM_AW-1:0] ld_addr;
    logic init_done;
    logic [7:0] rdata;
    sgc_pkg::sgc_tx_state_t tx_state;
    logic [2:0] ctl;
  } sgc_state_t;

  sgc_state_t s_q;
  sgc_state_t s_d;
  sgc_pkg::sgc_bus_req_t req;
  logic [7:0] rom_data;
  logic full_rst_n;
  logic lock_s;
  logic refclk_s;

  assign req.addr = addr_i;
  assign req.wdata = wdata_i;
  assign req.wr = wr_i;
  assign req.rd = rd_i;
  assign lock_s = s_q.lock_sync[1];
  assign refclk_s = s_q.refclk_sync[1];

  // (RQ3) Full reset resets registers
  assign full_rst_n = rst_n_i & ~s_q.full_pend;

  sgc_rom #(
    .DEPTH(ROM_DEPTH),
    .AW(ROM_AW)
  ) u_rom (
    .clk_i(clk_i),
    .addr_i(s_q.ld_addr),
    .data_o(rom_data)
  );

  function automatic logic [7:0] status_word(input logic done, input logic rclk);
    logic [7:0] w;
    w = 8'h00;
    w[sgc_pkg::STS_INIT_DONE_BIT] = done;
    w[sgc_pkg::STS_REFCLK_BIT] = rclk;
    return w;
  endfunction : status_word

  function automatic sgc_pkg::sgc_tx_state_t tx_pick(input logic [7:0] c, input logic lock);
    sgc_pkg::sgc_tx_state_t t;
    t = sgc_pkg::SGC_TX_NORMAL;
    if (c[sgc_pkg::CFG_IDLE_CHOICE_BIT] && !c[sgc_pkg::CFG_OUT_ENABLE_BIT]) begin
      // (RQ9) Forced high impedance
      t = sgc_pkg::SGC_TX_HIZ;
    end else if (!lock) begin
      if (!c[sgc_pkg::CFG_NOLOCK_POLICY_BIT]) begin
        // (RQ7) No lock high impedance
        t = sgc_pkg::SGC_TX_HIZ;
      end else if (!c[sgc_pkg::CFG_IDLE_CHOICE_BIT]) begin
        // (RQ10) No lock HS-0
        t = sgc_pkg::SGC_TX_HS0;
      end else begin
        // (RQ8) No lock LP-11
        t = sgc_pkg::SGC_TX_LP11;
      end
    end
    return t;
  endfunction : tx_pick

  always_comb begin
    s_d = s_q;
    s_d.lock_sync = {s_q.lock_sync[0], any_rx_lock_i};
    s_d.refclk_sync = {s_q.refclk_sync[0], refclk_detect_i};
    s_d.rdata = 8'h00;

    // (RQ4) Logic reset pulse, registers kept
    if (s_q.logic_pend) begin
      if (s_q.logic_cnt == sgc_pkg::LOGIC_RST_CYCLES) begin
        // (RQ16) Clear once done
        s_d.logic_pend = 1'b0;
        s_d.logic_cnt = 4'h0;
      end else begin
        s_d.logic_cnt = s_q.logic_cnt + 4'h1;
      end
    end

    // (RQ1) ROM load sequence
    case (s_q.ld_state)
      sgc_pkg::SGC_LD_IDLE: begin
        if (s_q.reload_pend) begin
          s_d.ld_state = sgc_pkg::SGC_LD_RUN;
          s_d.ld_addr = '0;
          s_d.init_done = 1'b0;
        end
      end
      sgc_pkg::SGC_LD_RUN: begin
        if (s_q.ld_addr == ROM_AW'(ROM_DEPTH - 1)) begin
          s_d.ld_state = sgc_pkg::SGC_LD_DONE;
        end else begin
          s_d.ld_addr = s_q.ld_addr + ROM_AW'(1);
        end
      end
      sgc_pkg::SGC_LD_DONE: begin
        // Registered ROM word of the last address is now valid
        s_d.cfg = rom_data & sgc_pkg::CFG_WRITE_MASK;
        // (RQ15) Init done set
        s_d.init_done = 1'b1;
        // (RQ16) Reload bit clears
        s_d.reload_pend = 1'b0;
        s_d.ld_state = sgc_pkg::SGC_LD_IDLE;
      end
      default: begin
        s_d.ld_state = sgc_pkg::SGC_LD_IDLE;
      end
    endcase

    // Register writes; a load in progress owns the configuration last
    if (req.wr) begin
      if (req.addr == sgc_pkg::SOFT_RESET_CONTROL_OFS) begin
        if (req.wdata[sgc_pkg::RST_RELOAD_BIT]) begin
          s_d.reload_pend = 1'b1;
        end
        if (req.wdata[sgc_pkg::RST_FULL_BIT]) begin
          s_d.full_pend = 1'b1;
        end
        if (req.wdata[sgc_pkg::RST_LOGIC_BIT]) begin
          s_d.logic_pend = 1'b1;
          s_d.logic_cnt = 4'h0;
        end
      end else if (req.addr == sgc_pkg::GENERAL_CONFIGURATION_OFS) begin
        if (s_q.ld_state != sgc_pkg::SGC_LD_DONE) begin
          // (RQ14) Reserved bits dropped
          s_d.cfg = req.wdata & sgc_pkg::CFG_WRITE_MASK;
        end
      end
      // (RQ13) Ident writes ignored
    end

    // Register reads
    if (req.rd) begin
      if (req.addr == sgc_pkg::SOFT_RESET_CONTROL_OFS) begin
        // (RQ16) Pending bits read one
        s_d.rdata = {5'h00, s_q.reload_pend, s_q.full_pend, s_q.logic_pend};
      end else if (req.addr == sgc_pkg::GENERAL_CONFIGURATION_OFS) begin
        s_d.rdata = s_q.cfg;
      end else if (req.addr == sgc_pkg::SILICON_REVISION_IDENT_OFS) begin
        // (RQ13) Revision and mask nibbles
        s_d.rdata = {sgc_pkg::SILICON_REV_DEFAULT, sgc_pkg::MASK_REV_DEFAULT};
      end else if (req.addr == sgc_pkg::DEVICE_STATUS_REG_OFS) begin
        s_d.rdata = status_word(s_q.init_done, s_q.ctl[0]);
      end else begin
        s_d.rdata = 8'h00;
      end
    end

    s_d.tx_state = tx_pick(s_q.cfg, lock_s);
    // (RQ12) Reference clock override
    s_d.ctl[0] = s_q.cfg[sgc_pkg::CFG_REFCLK_OVR_BIT] | refclk_s;
    // (RQ11) Parity checker enable
    s_d.ctl[1] = s_q.cfg[sgc_pkg::CFG_PARITY_EN_BIT] & ~s_q.logic_pend;
    // (RQ6) I2C controller enable
    s_d.ctl[2] = s_q.cfg[sgc_pkg::CFG_I2C_CTRL_EN_BIT] & ~s_q.logic_pend;
  end

  // Full reset is an asynchronous pulse shorter than a cycle; it clears its own request flop
  always_ff @(posedge clk_i or negedge full_rst_n) begin
    if (!full_rst_n) begin
      s_q.lock_sync <= 2'h0;
      s_q.refclk_sync <= 2'h0;
      s_q.cfg <= sgc_pkg::CFG_RESET;
      s_q.reload_pend <= 1'b0;
      s_q.full_pend <= 1'b0;
      s_q.logic_pend <= 1'b0;
      s_q.logic_cnt <= 4'h0;
      s_q.ld_state <= sgc_pkg::SGC_LD_IDLE;
      s_q.ld_addr <= '0;
      s_q.init_done <= 1'b1;
      s_q.rdata <= 8'h00;
      s_q.tx_state <= sgc_pkg::SGC_TX_HIZ;
      s_q.ctl <= {sgc_pkg::CFG_RESET[sgc_pkg::CFG_I2C_CTRL_EN_BIT],
                  sgc_pkg::CFG_RESET[sgc_pkg::CFG_PARITY_EN_BIT],
                  sgc_pkg::CFG_RESET[sgc_pkg::CFG_REFCLK_OVR_BIT]};
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_o = s_q.rdata;
  assign tx_state_o = s_q.tx_state;
  assign refclk_present_o = s_q.ctl[0];
  assign parity_check_en_o = s_q.ctl[1];
  assign i2c_ctrl_en_o = s_q.ctl[2];
  assign logic_reset_o = s_q.logic_pend;
  assign init_done_o = s_q.init_done;

endmodule : sgc_top

// ===== testbench/sgc_checker.sv
`timescale 1ns/1ps
module sgc_checker #(
  parameter int unsigned ROM_DEPTH = 8,
  parameter int unsigned ROM_AW = 3
) (
  // Clock, reset, bus
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  // Pins and controls
  input wire logic any_rx_lock_i,
  input wire logic refclk_detect_i,
  input wire logic i2c_ctrl_en_o,
  input wire logic parity_check_en_o,
  input wire logic refclk_present_o,
  input wire sgc_pkg::sgc_tx_state_t tx_state_o,
  input wire logic logic_reset_o,
  input wire logic init_done_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire logic wr_rst = wr_i && addr_i == 8'h01;
  unmapped_zero_a: assert property ($past(rd_i && (addr_i == 8'h00 || addr_i > 8'h04)) |->
    rdata_o == 8'h00) else $error("unmapped read not zero");
  ident_ro_a: assert property ($past(rd_i && addr_i == 8'h03) |->
    rdata_o == {sgc_pkg::SILICON_REV_DEFAULT, sgc_pkg::MASK_REV_DEFAULT}) else $error("ident");
  cfg_rsvd_a: assert property ($past(rd_i && addr_i == 8'h02) |-> rdata_o[7:6] == 2'h0)
    else $error("cfg reserved bits set");
  ctl_rsvd_a: assert property ($past(rd_i && addr_i == 8'h01) |-> rdata_o[7:3] == 5'h00)
    else $error("reset control reserved bits set");
  logic_pulse_a: assert property (wr_rst && wdata_i[0] && !wdata_i[1] |=>
    logic_reset_o [*5] ##1 !logic_reset_o) else $error("logic reset pulse length");
  logic_gate_a: assert property (logic_reset_o && $past(logic_reset_o) |->
    !i2c_ctrl_en_o && !parity_check_en_o) else $error("enables live in logic reset");
  reload_done_a: assert property (wr_rst && wdata_i[2] && !wdata_i[1] |->
    ##[1:3] !init_done_o ##[1:20] init_done_o) else $error("reload init flag");
  full_reset_a: assert property (wr_rst && wdata_i[1] |->
    ##[1:3] (parity_check_en_o && !i2c_ctrl_en_o && init_done_o)) else $error("full reset");
  refclk_det_a: assert property ($past(refclk_detect_i, 3) && $past(refclk_detect_i, 4) |->
    refclk_present_o) else $error("refclk detect not passed");
  cover property (wr_rst && wdata_i[2]);
  cover property (logic_reset_o);
  cover property (tx_state_o == sgc_pkg::SGC_TX_LP11);
endmodule : sgc_checker
bind sgc_top sgc_checker #(.ROM_DEPTH(ROM_DEPTH), .ROM_AW(ROM_AW)) chk_u (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .any_rx_lock_i(any_rx_lock_i),
  .refclk_detect_i(refclk_detect_i), .i2c_ctrl_en_o(i2c_ctrl_en_o),
  .parity_check_en_o(parity_check_en_o), .refclk_present_o(refclk_present_o),
  .tx_state_o(tx_state_o), .logic_reset_o(logic_reset_o), .init_done_o(init_done_o));

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0] IDENT = {sgc_pkg::SILICON_REV_DEFAULT, sgc_pkg::MASK_REV_DEFAULT};
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic lock = 1'b0;
  logic det = 1'b0;
  logic [7:0] rdata_o, v;
  logic i2c, par, ref_o, lrst, idone;
  sgc_pkg::sgc_tx_state_t tx;
  int n_mismatch = 0;
  int samples_checked = 0;
  always #10 clk_i = ~clk_i;
  sgc_top #(.ROM_DEPTH(2), .ROM_AW(1)) dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .any_rx_lock_i(lock), .refclk_detect_i(det), .i2c_ctrl_en_o(i2c),
    .parity_check_en_o(par), .refclk_present_o(ref_o), .tx_state_o(tx),
    .logic_reset_o(lrst), .init_done_o(idone));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk("rdata", v, e);
  endtask : rc
  task automatic wc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : wc
  // Expected transmitter state from lock and cfg bits 4:2
  function automatic logic [3:0] txexp(input logic lk, input logic [2:0] c);
    if (c[0] && !c[1]) return 4'h2;
    if (lk) return 4'h1;
    if (!c[2]) return 4'h2;
    return c[0] ? 4'h4 : 4'h8;
  endfunction : txexp
  task automatic t_reset();
    rc(8'h01, 8'h00);
    rc(8'h02, 8'h1E);
    rc(8'h03, IDENT);
    rd(8'h04);
    chk("init", 8'(v[6]), 8'h01);
    rc(8'h20, 8'h00);
    wr(8'h03, 8'h5C);
    rc(8'h03, IDENT);
    wr(8'h01, 8'hF8);
    rc(8'h01, 8'h00);
    wr(8'h02, 8'hC0);
    rc(8'h02, 8'h00);
  endtask : t_reset
  task automatic t_cfg();
    wr(8'h02, 8'h21);
    wc(3);
    chk("i2c", 8'(i2c), 8'h01);
    chk("par", 8'(par), 8'h00);
    chk("ref", 8'(ref_o), 8'h01);
    wr(8'h02, 8'h02);
    wc(3);
    chk("i2c", 8'(i2c), 8'h00);
    chk("par", 8'(par), 8'h01);
    chk("ref", 8'(ref_o), 8'h00);
    @(posedge clk_i) det <= 1'b1;
    wc(5);
    chk("ref", 8'(ref_o), 8'h01);
    @(posedge clk_i) det <= 1'b0;
  endtask : t_cfg
  // Every lock and output mode combination
  task automatic t_tx();
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_i) lock <= i[3];
      wr(8'h02, {3'h0, i[2:0], 2'h2});
      wc(6);
      chk("tx", 8'(tx), 8'(txexp(i[3], i[2:0])));
    end
  endtask : t_tx
  // logic reset keeps cfg, as software prefers
  task automatic t_logic();
    wr(8'h02, 8'h3F);
    wr(8'h01, 8'h01);
    rc(8'h01, 8'h01);
    chk("lrst", 8'(lrst), 8'h01);
    chk("i2c", 8'(i2c), 8'h00);
    chk("par", 8'(par), 8'h00);
    wc(6);
    rc(8'h01, 8'h00);
    chk("lrst", 8'(lrst), 8'h00);
    rc(8'h02, 8'h3F);
    chk("i2c", 8'(i2c), 8'h01);
  endtask : t_logic
  task automatic t_reload();
    bit z, ok;
    wr(8'h01, 8'h04);
    rc(8'h01, 8'h04);
    for (int k = 0; k < 40 && !ok; k++) begin
      rd(8'h04);
      if (v[6] === 1'b0) z = 1'b1;
      else if (z) ok = 1'b1;
    end
    chk("poll", 8'(ok), 8'h01);
    chk("idone", 8'(idone), 8'h01);
    if (!ok) complete_run();
    rc(8'h02, 8'h1E);
    rc(8'h01, 8'h00);
  endtask : t_reload
  // Full reset drops cfg
  task automatic t_full();
    wr(8'h02, 8'h21);
    wr(8'h01, 8'h02);
    wc(3);
    chk("i2c", 8'(i2c), 8'h00);
    chk("par", 8'(par), 8'h01);
    chk("idone", 8'(idone), 8'h01);
    rc(8'h02, 8'h1E);
    rc(8'h01, 8'h00);
  endtask : t_full
  initial begin
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_cfg();
    t_tx();
    t_logic();
    t_reload();
    t_full();
    complete_run();
  end
endmodule : tb_top
